// *** rtl/pag_consts.svh ***
// Functional notes
// - protect 0: write only stopped, panel mode
// - protect 0: carrier writes running panel only
// - protect 1: refuse writes, keep serving reads
// - protect 1: refuse clear and all clear
// - protect 1: listed settings stay writable
// - protect 2: writes in any mode, state
// - protect 2: listed settings locked while running
// - protect 2: input terminal assignments locked running
// - protect 2: output terminal assignments locked running
// - protect setting writable in any mode, state
// - protect, direction lock need extended view
// - direction lock: 0 both, 1 no rev, 2 no fwd
// - direction lock covers every command source
// - view 9999 basic only, 0 basic plus extended
// - serial reads see all unless source select 2
// - fitted unit makes jog, contrast basic
// - source select 9999: unit beats panel
`ifndef PAG_CONSTS_SVH
`define PAG_CONSTS_SVH

`define PAG_WP_RESET 16'h0000
`define PAG_DIR_RESET 16'h0000
`define PAG_VIEW_RESET 16'h270f

`define PAG_WP_STOP_ONLY 16'h0000
`define PAG_WP_LOCKED 16'h0001
`define PAG_WP_ALWAYS 16'h0002

`define PAG_DIR_NO_REV 16'h0001
`define PAG_DIR_NO_FWD 16'h0002
`define PAG_DIR_MAX 16'h0002

`define PAG_VIEW_ALL 16'h0000
`define PAG_VIEW_BASIC 16'h270f

`define PAG_LCS_SERIAL 16'h0002
`define PAG_LCS_UNIT_PRIO 16'h270f

`define PAG_RD_ZERO 16'h0000

`define PAG_PN_WP 10'h04d
`define PAG_PN_DIR 10'h04e
`define PAG_PN_VIEW 10'h0a0
`define PAG_PN_CARRIER 10'h048
`define PAG_PN_SOFT_CARRIER 10'h0f0

`define PAG_UNIT_BASIC_LIST 10'h00f, 10'h010, 10'h3df
`define PAG_BASIC_LIST 10'h000, 10'h001, 10'h002, 10'h003, 10'h004, 10'h005, \
  10'h006, 10'h007, 10'h008, 10'h009, 10'h04f
`define PAG_EXEMPT_LIST 10'h016, 10'h04b, 10'h04d, 10'h04f, 10'h0a0, 10'h128, 10'h129
`define PAG_RUNLOCK_LIST 10'h017, 10'h028, 10'h030, 10'h03c, 10'h042, 10'h047, \
  10'h04f, 10'h050, 10'h052, 10'h053, 10'h054, 10'h05a, 10'h060, 10'h0ff, 10'h100, \
  10'h101, 10'h102, 10'h105, 10'h12a, 10'h157, 10'h1c2, 10'h231, 10'h233, 10'h234
`define PAG_IN_TERM_LIST 10'h0b2, 10'h0b3, 10'h0b4, 10'h0b5, 10'h0b6
`define PAG_OUT_TERM_LIST 10'h0be, 10'h0c0, 10'h0c5

`endif

// *** rtl/pag_pkg.sv ***
package pag_pkg;

  typedef logic [9:0] pag_num_t;

  typedef enum logic [1:0] {
    PAG_MODE_PANEL = 2'b00,
    PAG_MODE_EXTERNAL = 2'b01,
    PAG_MODE_NET = 2'b10
  } pag_mode_e;

  typedef enum logic [1:0] {
    PAG_SRC_PANEL = 2'b00,
    PAG_SRC_UNIT = 2'b01,
    PAG_SRC_SERIAL = 2'b10
  } pag_src_e;

  typedef struct packed {
    logic [15:0] write_protect_select;
    logic [15:0] direction_lock_select;
    logic [15:0] extended_view_select;
    logic wr_done;
    logic wr_refused;
    logic clr_done;
    logic clr_refused;
    logic rd_done;
    logic rd_refused;
    logic [15:0] rd_data;
    logic store_strobe;
    pag_num_t store_num;
    logic [15:0] store_data;
    logic run_fwd;
    logic run_rev;
    logic unit_is_local;
    logic fwd_s1;
    logic fwd_s2;
    logic rev_s1;
    logic rev_s2;
  } pag_state_s;

endpackage : pag_pkg

// *** rtl/pag_class_if.sv ***
interface pag_class_if;
  pag_pkg::pag_num_t num;
  logic unit_fitted;
  logic basic;
  logic exempt;
  logic runlock;
  logic carrier;

  modport classifier(input num, input unit_fitted,
                     output basic, output exempt, output runlock, output carrier);
  modport user(output num, output unit_fitted,
               input basic, input exempt, input runlock, input carrier);
endinterface : pag_class_if

// *** rtl/pag_classifier.sv ***
`include "pag_consts.svh"

module pag_classifier (
  pag_class_if.classifier c
);

  always_comb begin
    c.basic = 1'b0;
    c.exempt = 1'b0;
    c.runlock = 1'b0;
    c.carrier = 1'b0;
    case (c.num)
      `PAG_BASIC_LIST: c.basic = 1'b1;
      `PAG_UNIT_BASIC_LIST: c.basic = c.unit_fitted;
      default: c.basic = 1'b0;
    endcase
    case (c.num)
      `PAG_EXEMPT_LIST: c.exempt = 1'b1;
      default: c.exempt = 1'b0;
    endcase
    case (c.num)
      `PAG_RUNLOCK_LIST: c.runlock = 1'b1;
      `PAG_IN_TERM_LIST: c.runlock = 1'b1;
      `PAG_OUT_TERM_LIST: c.runlock = 1'b1;
      default: c.runlock = 1'b0;
    endcase
    c.carrier = (c.num == `PAG_PN_CARRIER) || (c.num == `PAG_PN_SOFT_CARRIER);
  end

endmodule : pag_classifier

// *** rtl/pag_guard.sv ***
`include "pag_consts.svh"

module pag_guard (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_running,
  input wire logic [1:0] i_op_mode,
  input wire logic i_unit_fitted,
  input wire logic [15:0] i_local_command_source_select,
  input wire logic i_wr_req,
  input wire logic [1:0] i_wr_src,
  input wire logic [9:0] i_wr_num,
  input wire logic [15:0] i_wr_data,
  input wire logic i_clear_req,
  input wire logic i_all_clear_req,
  input wire logic i_rd_req,
  input wire logic [1:0] i_rd_src,
  input wire logic [9:0] i_rd_num,
  input wire logic i_panel_fwd,
  input wire logic i_panel_rev,
  input wire logic i_unit_fwd,
  input wire logic i_unit_rev,
  input wire logic i_start_forward,
  input wire logic i_start_reverse,
  input wire logic i_serial_fwd,
  input wire logic i_serial_rev,
  output logic o_wr_done,
  output logic o_wr_refused,
  output logic o_clr_done,
  output logic o_clr_refused,
  output logic o_rd_done,
  output logic o_rd_refused,
  output logic [15:0] o_rd_data,
  output logic o_store_strobe,
  output logic [9:0] o_store_num,
  output logic [15:0] o_store_data,
  output logic o_run_fwd,
  output logic o_run_rev,
  output logic o_unit_is_local
);

  ////////////////////////////////////////////////////////////////////////////////
  // state, classification

  localparam pag_pkg::pag_state_s RESET_STATE = '{
    write_protect_select: `PAG_WP_RESET,
    direction_lock_select: `PAG_DIR_RESET,
    extended_view_select: `PAG_VIEW_RESET,
    rd_data: `PAG_RD_ZERO,
    store_num: '0,
    store_data: '0,
    default: 1'b0
  };

  pag_pkg::pag_state_s st;
  pag_pkg::pag_state_s next_st;
  pag_pkg::pag_mode_e mode;
  pag_pkg::pag_src_e wr_src;
  pag_pkg::pag_src_e rd_src;
  logic wr_visible;
  logic rd_visible;
  logic val_ok;
  logic wr_ok;
  logic clr_ok;
  logic clear_any;
  logic cmd_fwd;
  logic cmd_rev;

  pag_class_if wcls ();
  pag_class_if rcls ();

  assign wcls.num = i_wr_num;
  assign wcls.unit_fitted = i_unit_fitted;
  assign rcls.num = i_rd_num;
  assign rcls.unit_fitted = i_unit_fitted;

  pag_classifier u_wr_class (
    .c(wcls.classifier)
  );

  pag_classifier u_rd_class (
    .c(rcls.classifier)
  );

  assign mode = pag_pkg::pag_mode_e'(i_op_mode);
  assign wr_src = pag_pkg::pag_src_e'(i_wr_src);
  assign rd_src = pag_pkg::pag_src_e'(i_rd_src);

  ////////////////////////////////////////////////////////////////////////////////
  // access decisions

  function automatic logic can_see(input pag_pkg::pag_src_e src, input logic basic,
                                   input logic [15:0] view, input logic [15:0] lcs);
    can_see = ((src == pag_pkg::PAG_SRC_SERIAL) && (lcs != `PAG_LCS_SERIAL))
              || (view == `PAG_VIEW_ALL) || basic;
  endfunction : can_see

  function automatic logic write_allowed(input logic [15:0] wp, input logic running,
                                         input pag_pkg::pag_mode_e md, input logic exempt,
                                         input logic runlock, input logic carrier,
                                         input logic is_wp);
    if (is_wp) begin
      write_allowed = 1'b1;
    end else if (wp == `PAG_WP_LOCKED) begin
      write_allowed = exempt;
    end else if (wp == `PAG_WP_ALWAYS) begin
      write_allowed = !(running && runlock);
    end else if (wp == `PAG_WP_STOP_ONLY) begin
      write_allowed = (md == pag_pkg::PAG_MODE_PANEL) && (!running || carrier);
    end else begin
      write_allowed = 1'b0;
    end
  endfunction : write_allowed

  assign wr_visible = can_see(wr_src, wcls.basic, st.extended_view_select,
                              i_local_command_source_select);
  assign rd_visible = can_see(rd_src, rcls.basic, st.extended_view_select,
                              i_local_command_source_select);

  always_comb begin
    if (i_wr_num == `PAG_PN_WP) begin
      val_ok = i_wr_data <= `PAG_WP_ALWAYS;
    end else if (i_wr_num == `PAG_PN_DIR) begin
      val_ok = i_wr_data <= `PAG_DIR_MAX;
    end else if (i_wr_num == `PAG_PN_VIEW) begin
      val_ok = (i_wr_data == `PAG_VIEW_ALL) || (i_wr_data == `PAG_VIEW_BASIC);
    end else begin
      val_ok = 1'b1;
    end
  end

  assign wr_ok = wr_visible && val_ok &&
                 write_allowed(st.write_protect_select, i_running, mode, wcls.exempt,
                               wcls.runlock, wcls.carrier, i_wr_num == `PAG_PN_WP);
  assign clr_ok = write_allowed(st.write_protect_select, i_running, mode, 1'b0,
                                1'b0, 1'b0, 1'b0);
  assign clear_any = i_clear_req || i_all_clear_req;

  ////////////////////////////////////////////////////////////////////////////////
  // direction commands

  always_comb begin
    case (mode)
      pag_pkg::PAG_MODE_PANEL: begin
        cmd_fwd = st.unit_is_local ? i_unit_fwd : i_panel_fwd;
        cmd_rev = st.unit_is_local ? i_unit_rev : i_panel_rev;
      end
      pag_pkg::PAG_MODE_EXTERNAL: begin
        cmd_fwd = st.fwd_s2;
        cmd_rev = st.rev_s2;
      end
      pag_pkg::PAG_MODE_NET: begin
        cmd_fwd = i_serial_fwd;
        cmd_rev = i_serial_rev;
      end
      default: begin
        cmd_fwd = 1'b0;
        cmd_rev = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;
    next_st.fwd_s1 = i_start_forward;
    next_st.fwd_s2 = st.fwd_s1;
    next_st.rev_s1 = i_start_reverse;
    next_st.rev_s2 = st.rev_s1;
    next_st.wr_done = 1'b0;
    next_st.wr_refused = 1'b0;
    next_st.clr_done = 1'b0;
    next_st.clr_refused = 1'b0;
    next_st.rd_done = 1'b0;
    next_st.rd_refused = 1'b0;
    next_st.store_strobe = 1'b0;
    if (i_wr_req) begin
      if (wr_ok) begin
        next_st.wr_done = 1'b1;
        if (i_wr_num == `PAG_PN_WP) begin
          next_st.write_protect_select = i_wr_data;
        end else if (i_wr_num == `PAG_PN_DIR) begin
          next_st.direction_lock_select = i_wr_data;
        end else if (i_wr_num == `PAG_PN_VIEW) begin
          next_st.extended_view_select = i_wr_data;
        end else begin
          next_st.store_strobe = 1'b1;
          next_st.store_num = i_wr_num;
          next_st.store_data = i_wr_data;
        end
      end else begin
        next_st.wr_refused = 1'b1;
      end
    end
    if (clear_any) begin
      if (clr_ok) begin
        next_st.clr_done = 1'b1;
        next_st.direction_lock_select = `PAG_DIR_RESET;
        next_st.extended_view_select = `PAG_VIEW_RESET;
        if (i_all_clear_req) begin
          next_st.write_protect_select = `PAG_WP_RESET;
        end
      end else begin
        next_st.clr_refused = 1'b1;
      end
    end
    if (i_rd_req) begin
      next_st.rd_data = `PAG_RD_ZERO;
      if (rd_visible) begin
        next_st.rd_done = 1'b1;
        if (i_rd_num == `PAG_PN_WP) begin
          next_st.rd_data = st.write_protect_select;
        end else if (i_rd_num == `PAG_PN_DIR) begin
          next_st.rd_data = st.direction_lock_select;
        end else if (i_rd_num == `PAG_PN_VIEW) begin
          next_st.rd_data = st.extended_view_select;
        end
      end else begin
        next_st.rd_refused = 1'b1;
      end
    end
    next_st.run_fwd = cmd_fwd && (st.direction_lock_select != `PAG_DIR_NO_FWD);
    next_st.run_rev = cmd_rev && (st.direction_lock_select != `PAG_DIR_NO_REV);
    next_st.unit_is_local = i_unit_fitted &&
                            (i_local_command_source_select == `PAG_LCS_UNIT_PRIO);
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= RESET_STATE;
    end else begin
      st <= next_st;
    end
  end

  assign o_wr_done = st.wr_done;
  assign o_wr_refused = st.wr_refused;
  assign o_clr_done = st.clr_done;
  assign o_clr_refused = st.clr_refused;
  assign o_rd_done = st.rd_done;
  assign o_rd_refused = st.rd_refused;
  assign o_rd_data = st.rd_data;
  assign o_store_strobe = st.store_strobe;
  assign o_store_num = st.store_num;
  assign o_store_data = st.store_data;
  assign o_run_fwd = st.run_fwd;
  assign o_run_rev = st.run_rev;
  assign o_unit_is_local = st.unit_is_local;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  AST_WP0_STOP_ONLY: assert property (
    i_wr_req && st.write_protect_select == `PAG_WP_STOP_ONLY && i_wr_num != `PAG_PN_WP
    && !wcls.carrier && (i_running || mode != pag_pkg::PAG_MODE_PANEL)
    |=> o_wr_refused && !o_wr_done)
    else $error("write accepted outside stopped panel mode");

  AST_WP0_CARRIER: assert property (
    i_wr_req && st.write_protect_select == `PAG_WP_STOP_ONLY && wcls.carrier
    && wr_visible && mode == pag_pkg::PAG_MODE_PANEL |=> o_wr_done)
    else $error("carrier write refused in panel mode");

  AST_WP1_REFUSE: assert property (
    i_wr_req && st.write_protect_select == `PAG_WP_LOCKED && !wcls.exempt
    |=> o_wr_refused ##0 !o_store_strobe)
    else $error("write accepted under full protection");

  AST_WP1_CLEAR: assert property (
    clear_any && st.write_protect_select == `PAG_WP_LOCKED |=> o_clr_refused && !o_clr_done)
    else $error("clear accepted under full protection");

  AST_WP1_EXEMPT: assert property (
    i_wr_req && st.write_protect_select == `PAG_WP_LOCKED && wcls.exempt && wr_visible
    && val_ok |=> o_wr_done)
    else $error("exempt setting refused under full protection");

  AST_WP2_ANY: assert property (
    i_wr_req && st.write_protect_select == `PAG_WP_ALWAYS && !wcls.runlock && wr_visible
    && val_ok |=> o_wr_done)
    else $error("write refused with protection 2");

  AST_WP2_RUNLOCK: assert property (
    i_wr_req && st.write_protect_select == `PAG_WP_ALWAYS && i_running && wcls.runlock
    |=> o_wr_refused)
    else $error("run locked setting written while running");

  AST_WP_ANYTIME: assert property (
    i_wr_req && i_wr_num == `PAG_PN_WP && wr_visible && val_ok && !clear_any
    |=> o_wr_done && st.write_protect_select == $past(i_wr_data))
    else $error("protect setting write lost");

  AST_DIR_LOCK: assert property (
    st.direction_lock_select == `PAG_DIR_NO_REV |=> !o_run_rev)
    else $error("reverse run with reverse lock");

  AST_TERM_LOCK: assert property (
    mode == pag_pkg::PAG_MODE_EXTERNAL && st.fwd_s2
    && st.direction_lock_select == `PAG_DIR_NO_FWD ##1 st.direction_lock_select ==
    `PAG_DIR_NO_FWD |=> !o_run_fwd)
    else $error("terminal forward run with forward lock");

  AST_VIEW_BASIC: assert property (
    i_rd_req && rd_src != pag_pkg::PAG_SRC_SERIAL && !rcls.basic
    && st.extended_view_select == `PAG_VIEW_BASIC |=> o_rd_refused ##0 o_rd_data == '0)
    else $error("extended setting shown in basic view");

  AST_SERIAL_READ: assert property (
    i_rd_req && rd_src == pag_pkg::PAG_SRC_SERIAL
    && i_local_command_source_select != `PAG_LCS_SERIAL |=> o_rd_done)
    else $error("serial read refused");

  AST_UNIT_PRIO: assert property (
    i_unit_fitted && i_local_command_source_select == `PAG_LCS_UNIT_PRIO |=> o_unit_is_local)
    else $error("unit not given local priority");

  AST_REFUSE_KEEP: assert property (
    i_wr_req && !wr_ok && !clear_any
    |=> o_wr_refused && !o_store_strobe
    && st.write_protect_select == $past(st.write_protect_select)
    && st.extended_view_select == $past(st.extended_view_select))
    else $error("refused write changed a value");

endmodule : pag_guard

// *** tb/pag_host.sv ***
////////////////////////////////////////////////////////////////////////////////
// panel, plug-in unit or serial host: one request a call, one cycle long
module pag_host (
  input wire logic i_clock,
  output logic o_wr_req,
  output logic [1:0] o_wr_src,
  output logic [9:0] o_wr_num,
  output logic [15:0] o_wr_data,
  output logic o_clear_req,
  output logic o_all_clear_req,
  output logic o_rd_req,
  output logic [1:0] o_rd_src,
  output logic [9:0] o_rd_num
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    {o_wr_req, o_clear_req, o_all_clear_req, o_rd_req} = '0;
    {o_wr_src, o_wr_num, o_wr_data, o_rd_src, o_rd_num} = '0;
  end

  // kind: 0 write, 1 read, 2 clear, 3 all clear
  task automatic op(input int k, input logic [1:0] s, input logic [9:0] n,
                    input logic [15:0] d);
    @(negedge i_clock);
    o_wr_req = (k == 0);
    o_rd_req = (k == 1);
    o_clear_req = (k == 2);
    o_all_clear_req = (k == 3);
    {o_wr_src, o_rd_src, o_wr_num, o_rd_num, o_wr_data} = {s, s, n, n, d};
    @(negedge i_clock);
    {o_wr_req, o_rd_req, o_clear_req, o_all_clear_req} = '0;
    // released number and data lines do not keep the last value; source lines do
    {o_wr_num, o_rd_num, o_wr_data} = ~{o_wr_num, o_rd_num, o_wr_data};
  endtask : op
endmodule : pag_host

// *** tb/testbench.sv ***
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic i_clock = 0;
  logic i_rst_n = 0;
  logic running = 0;
  logic fit = 0;
  logic [1:0] mode = 0;
  logic [15:0] lcs = 0;
  logic [7:0] keys = 0;
  logic wr_req, clear_req, all_clear_req, rd_req;
  logic [1:0] wr_src, rd_src;
  logic [9:0] wr_num, rd_num, o_store_num;
  logic [15:0] wr_data, o_rd_data, o_store_data;
  logic o_wr_done, o_wr_refused, o_clr_done, o_clr_refused, o_rd_done, o_rd_refused;
  logic o_store_strobe, o_run_fwd, o_run_rev, o_unit_is_local;
  int n_mismatch = 0;
  int checks_done = 0;
  int wp = 0;
  int dl = 0;
  int vw = 9999;

  always #50 i_clock = ~i_clock;

  pag_host host (.i_clock(i_clock), .o_wr_req(wr_req), .o_wr_src(wr_src),
    .o_wr_num(wr_num), .o_wr_data(wr_data), .o_clear_req(clear_req),
    .o_all_clear_req(all_clear_req), .o_rd_req(rd_req), .o_rd_src(rd_src),
    .o_rd_num(rd_num));

  pag_guard uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_running(running),
    .i_op_mode(mode), .i_unit_fitted(fit), .i_local_command_source_select(lcs),
    .i_wr_req(wr_req), .i_wr_src(wr_src), .i_wr_num(wr_num), .i_wr_data(wr_data),
    .i_clear_req(clear_req), .i_all_clear_req(all_clear_req), .i_rd_req(rd_req),
    .i_rd_src(rd_src), .i_rd_num(rd_num), .i_panel_fwd(keys[7]), .i_panel_rev(keys[6]),
    .i_unit_fwd(keys[5]), .i_unit_rev(keys[4]), .i_start_forward(keys[3]),
    .i_start_reverse(keys[2]), .i_serial_fwd(keys[1]), .i_serial_rev(keys[0]),
    .o_wr_done(o_wr_done), .o_wr_refused(o_wr_refused), .o_clr_done(o_clr_done),
    .o_clr_refused(o_clr_refused), .o_rd_done(o_rd_done), .o_rd_refused(o_rd_refused),
    .o_rd_data(o_rd_data), .o_store_strobe(o_store_strobe), .o_store_num(o_store_num),
    .o_store_data(o_store_data), .o_run_fwd(o_run_fwd), .o_run_rev(o_run_rev),
    .o_unit_is_local(o_unit_is_local));

  ////////////////////////////////////////////////////////////////////////////////
  // reference model
  function automatic bit vis(int s, int n);
    return vw == 0 || n inside {[0:9], 79} || (fit && n inside {15, 16, 991}) ||
      (s == 2 && lcs != 2);
  endfunction : vis

  task automatic do_op(input int k, input int s, input int n, input int d);
    bit v, rng, pr, ok;
    int e;
    v = vis(s, n);
    rng = (n == 77 || n == 78) ? d <= 2 : (n == 160 ? (d == 0 || d == 9999) : 1);
    if (n == 77) pr = 1;
    else if (wp == 0) pr = mode == 0 && (!running || n == 72 || n == 240);
    else if (wp == 1) pr = n inside {22, 75, 77, 79, 160, 296, 297};
    else pr = !(running && n inside {23, 40, 48, 60, 66, 71, 79, 80, 82, 83, 84, 90,
      96, [178:182], 190, 192, 197, [255:258], 261, 298, 343, 450, 561, 563, 564});
    if (k >= 2) pr = wp == 2 || (wp == 0 && mode == 0 && !running);
    ok = v && rng && pr;
    e = !v ? 0 : n == 77 ? wp : n == 78 ? dl : n == 160 ? vw : 0;
    host.op(k, 2'(s), 10'(n), 16'(d));
    if (k == 0) begin
      `CHK(o_wr_done, ok)
      `CHK(o_wr_refused, !ok)
      `CHK(o_store_strobe, ok && !(n inside {77, 78, 160}))
      if (o_store_strobe === 1'b1) `CHK({o_store_num, o_store_data}, {10'(n), 16'(d)})
      if (ok && n == 77) wp = d;
      if (ok && n == 78) dl = d;
      if (ok && n == 160) vw = d;
    end else if (k == 1) begin
      `CHK({o_rd_done, o_rd_refused}, {v, !v})
      `CHK(o_rd_data, 16'(e))
    end else begin
      `CHK({o_clr_done, o_clr_refused}, {pr, !pr})
      if (pr) begin
        dl = 0;
        vw = 9999;
        if (k == 3) wp = 0;
      end
    end
  endtask : do_op

  ////////////////////////////////////////////////////////////////////////////////
  // sequence
  task automatic do_reset();
    i_rst_n = 0;
    keys = 0; // start terminals low across reset
    repeat (10) @(negedge i_clock);
    i_rst_n = 1;
    {wp, dl, vw} = {32'd0, 32'd0, 32'd9999};
    lcs = 0;
    do_op(1, 2, 77, 0);
    do_op(1, 2, 78, 0);
    do_op(1, 2, 160, 0);
    do_op(1, 0, 77, 0);
    do_op(0, 0, 78, 1);
    $display("test reset done");
  endtask : do_reset

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    #(100 * 30000);
    n_mismatch++;
    finish_test();
  end

  initial begin
    static int nums[16] = '{0, 5, 15, 22, 40, 72, 77, 78, 79, 160, 180, 192, 240, 297, 500, 991};
    static int sel[3] = '{0, 2, 9999};
    int k, n, d, ef, er;
    logic [7:0] kr;
    void'($urandom(4));
    do_reset();
    repeat (600) begin
      running = 1'($urandom);
      mode = 2'($urandom % 3);
      lcs = 16'(sel[$urandom % 3]);
      fit = 1'($urandom);
      keys = 8'($urandom);
      k = $urandom % 8;
      n = nums[$urandom % 16];
      d = (n == 77 || n == 78) ? $urandom % 4 : (n == 160 ? sel[$urandom % 3] : $urandom % 65536);
      do_op(k < 5 ? 0 : (k < 7 ? 1 : 2 + $urandom % 2), $urandom % 3, n, d);
    end
    $display("test random access done");
    running = 0;
    lcs = 16'd9999;
    do_op(0, 2, 77, 2);
    for (int l = 0; l < 3; l++) begin
      do_op(0, 2, 78, l);
      repeat (12) begin
        mode = 2'($urandom % 3);
        fit = 1'($urandom);
        kr = 8'($urandom);
        keys = kr & ~((kr >> 1) & 8'h55);
        repeat (4) @(negedge i_clock);
        ef = mode == 0 ? (fit ? keys[5] : keys[7]) : (mode == 1 ? keys[3] : keys[1]);
        er = mode == 0 ? (fit ? keys[4] : keys[6]) : (mode == 1 ? keys[2] : keys[0]);
        `CHK(o_unit_is_local, fit)
        `CHK({o_run_fwd, o_run_rev}, {ef != 0 && l != 2, er != 0 && l != 1})
      end
    end
    $display("test direction lock done");
    do_reset();
    finish_test();
  end
endmodule : testbench
